// [design/pcmsr_bank.sv]
// Program counter and machine status register bank
// Operation
// - Program counter reads at selector zero; moves to it leave it unchanged.
// - Program counter read returns the address of the reading instruction.
// - Counter is 32 bits, or the address width up to 64 in 64-bit mode.
// - Reset loads the counter with the base-vector parameter.
// - Status read returns the carry in the carry-copy bit.
// - Status written by move at selector one, and by bit set or clear.
// - Bit set or clear: carry changes at once, other bits two cycles later.
// - Move write: carry takes effect one cycle later, all other bits two cycles later.
// - Writes to the carry-copy position are discarded.
// - Virtual mode bit enables translation and protection, or protection only.
// - Save bits exist only with a qualifying MMU and area setting.
// - User mode bit clear is privileged, set forbids certain instructions.
// - Version-register-present bit is read-only and fixed by configuration.
// - Exception-in-progress reads one while an exception is handled.
// - Exception enable allows hardware exceptions; exists with exceptions or MMU.
// - MMU exceptions are always taken regardless of exception enable.
// - Cache enable bits turn caches on, present only with that cache.
// - Divide flag sets on divide by zero or overflow, with a divider.
// - Divide flag sets whether or not exception handling is configured.
// - Stream error flag is sticky, cleared only by move or bit clear.
// - Break-in-progress sets on software, hardware or non-maskable break.
// - Carry reads one for carry, no borrow; zero for borrow.
// - Interrupt enable permits interrupts when set.
// - Bits use 32-bit layout or shift by 32 in 64-bit mode.
`timescale 1ns/1ns
module pcmsr_bank
	import pcmsr_pkg::*;
#(
	parameter int                 DATA_W                  = 32,
	parameter int                 ADDR_W                  = 32,
	parameter logic [ADDR_W-1:0]  vector_base_param       = '0,
	parameter int                 mmu_config_param        = 0,
	parameter int                 area_opt_param          = 0,
	parameter bit                 version_reg_param       = 1'b0,
	parameter bit                 exception_param         = 1'b0,
	parameter bit                 dcache_present_param    = 1'b0,
	parameter bit                 icache_present_param    = 1'b0,
	parameter bit                 divider_present_param   = 1'b0,
	parameter int                 stream_link_count_param = 0
) (
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	// Pipeline program counter update
	input  wire logic                   pc_load,
	input  wire logic [ADDR_W-1:0]      pc_next,
	// Special register read
	input  wire logic [PCMSR_SEL_W-1:0] special_reg_selector_a,
	output logic      [DATA_W-1:0]      special_rd_data,
	// Special register write
	input  wire logic                   move_to_special,
	input  wire logic [PCMSR_SEL_W-1:0] special_reg_selector_x,
	input  wire logic [DATA_W-1:0]      move_to_special_data,
	input  wire logic                   status_bit_set_instr,
	input  wire logic                   status_bit_clear_instr,
	input  wire logic [DATA_W-1:0]      status_bit_mask,
	// Hardware events
	input  wire logic                   carry_update,
	input  wire logic                   carry_value,
	input  wire logic                   divide_fault_event,
	input  wire logic                   stream_mismatch_event,
	input  wire logic                   break_taken_event,
	input  wire logic                   exception_entry_event,
	input  wire logic                   exception_return_event,
	input  wire logic                   hw_exception_req,
	input  wire logic                   mmu_exception_req,
	// Status outputs
	output logic                        carry_flag,
	output logic      [DATA_W-1:0]      machine_status,
	output logic                        translation_enable,
	output logic                        protection_enable,
	output logic                        user_mode_bit,
	output logic                        exception_in_progress,
	output logic                        exception_take,
	output logic                        dcache_enable,
	output logic                        icache_enable,
	output logic                        break_in_progress,
	output logic                        irq_enable
);
	// ==========================================
	// Elaboration checks
	initial begin
		if (!(DATA_W == PCMSR_W32 || DATA_W == PCMSR_W64)) begin
			$error("DATA_W must be 32 or 64");
		end
		if (DATA_W == PCMSR_W32 && ADDR_W != PCMSR_W32) begin
			$error("ADDR_W must be 32 with 32-bit data");
		end
		if (ADDR_W < PCMSR_W32 || ADDR_W > DATA_W) begin
			$error("ADDR_W out of range");
		end
	end

	// ==========================================
	// Presence of optional bits
	localparam bit AREA_OK = (area_opt_param == PCMSR_AREA_SPEED) || (area_opt_param == PCMSR_AREA_FREQ);
	localparam bit HAS_VMS = (mmu_config_param > 1) && AREA_OK;
	localparam bit HAS_UMS = (mmu_config_param > 0) && AREA_OK;
	localparam bit HAS_EXC = exception_param || (mmu_config_param > 0);
	localparam bit HAS_FSL = stream_link_count_param > 0;

	localparam int P_CC  = pcmsr_pos(PCMSR_B_CC, DATA_W);
	localparam int P_VMS = pcmsr_pos(PCMSR_B_VMS, DATA_W);
	localparam int P_VM  = pcmsr_pos(PCMSR_B_VM, DATA_W);
	localparam int P_UMS = pcmsr_pos(PCMSR_B_UMS, DATA_W);
	localparam int P_UM  = pcmsr_pos(PCMSR_B_UM, DATA_W);
	localparam int P_PVR = pcmsr_pos(PCMSR_B_PVR, DATA_W);
	localparam int P_EIP = pcmsr_pos(PCMSR_B_EIP, DATA_W);
	localparam int P_EE  = pcmsr_pos(PCMSR_B_EE, DATA_W);
	localparam int P_DCE = pcmsr_pos(PCMSR_B_DCE, DATA_W);
	localparam int P_DZO = pcmsr_pos(PCMSR_B_DZO, DATA_W);
	localparam int P_ICE = pcmsr_pos(PCMSR_B_ICE, DATA_W);
	localparam int P_FSL = pcmsr_pos(PCMSR_B_FSL, DATA_W);
	localparam int P_BIP = pcmsr_pos(PCMSR_B_BIP, DATA_W);
	localparam int P_C   = pcmsr_pos(PCMSR_B_C, DATA_W);
	localparam int P_IE  = pcmsr_pos(PCMSR_B_IE, DATA_W);

	// Writable bits; carry-copy, version bit and reserved positions never store
	localparam logic [DATA_W-1:0] WR_MASK =
		(DATA_W'(HAS_VMS) << P_VMS) | (DATA_W'(mmu_config_param > 1) << P_VM) |
		(DATA_W'(HAS_UMS) << P_UMS) | (DATA_W'(mmu_config_param > 0) << P_UM) |
		(DATA_W'(HAS_EXC) << P_EIP) | (DATA_W'(HAS_EXC) << P_EE) |
		(DATA_W'(dcache_present_param) << P_DCE) | (DATA_W'(divider_present_param) << P_DZO) |
		(DATA_W'(icache_present_param) << P_ICE) | (DATA_W'(HAS_FSL) << P_FSL) |
		(DATA_W'(1) << P_BIP) | (DATA_W'(1) << P_IE);

	typedef struct packed {
		logic [DATA_W-1:0] bits;
		logic              carry;
		logic              pend_valid;
		logic [DATA_W-1:0] pend_set;
		logic [DATA_W-1:0] pend_clr;
	} pcmsr_state_t;

	pcmsr_state_t st;
	pcmsr_state_t next_st;

	logic [ADDR_W-1:0] pc_value;
	logic [DATA_W-1:0] pc_view;
	logic              mts_msr;
	logic              bit_op;
	logic              carry_now;

	pcmsr_pc #(
		.ADDR_W            (ADDR_W),
		.vector_base_param (vector_base_param)
	) u_pc (
		.clk             (clk),
		.sys_rst         (sys_rst),
		.pc_load         (pc_load),
		.pc_next         (pc_next),
		.program_counter (pc_value)
	);

	// The counter only advances after the reading instruction retires, so the value seen is its own
	assign pc_view = DATA_W'(pc_value);

	// Moves at selector zero are not decoded at all, so the counter cannot be written
	assign mts_msr = move_to_special && (special_reg_selector_x == PCMSR_SEL_MSR);
	assign bit_op  = status_bit_set_instr || status_bit_clear_instr;

	// ==========================================
	// Carry: bit set or clear acts in the same cycle, a move a cycle later
	always_comb begin
		carry_now = st.carry;
		if (status_bit_set_instr && status_bit_mask[P_C]) begin
			carry_now = 1'b1;
		end else if (status_bit_clear_instr && status_bit_mask[P_C]) begin
			carry_now = 1'b0;
		end
	end

	// ==========================================
	// Next state
	always_comb begin
		next_st            = st;
		next_st.pend_valid = 1'b0;
		next_st.pend_set   = '0;
		next_st.pend_clr   = '0;
		next_st.carry      = carry_now;
		if (carry_update) begin
			next_st.carry = carry_value;
		end
		if (mts_msr) begin
			next_st.pend_valid = 1'b1;
			next_st.pend_set   = move_to_special_data & WR_MASK;
			next_st.pend_clr   = ~move_to_special_data & WR_MASK;
			next_st.carry      = move_to_special_data[P_C];
		end else if (bit_op) begin
			next_st.pend_valid = 1'b1;
			next_st.pend_set   = status_bit_set_instr ? (status_bit_mask & WR_MASK) : '0;
			next_st.pend_clr   = status_bit_clear_instr ? (status_bit_mask & WR_MASK) : '0;
		end
		// Delayed write lands, then hardware events override it so no event is lost
		if (st.pend_valid) begin
			next_st.bits = (st.bits & ~st.pend_clr) | st.pend_set;
		end
		if (divide_fault_event && divider_present_param) begin
			next_st.bits[P_DZO] = 1'b1;
		end
		if (stream_mismatch_event && HAS_FSL) begin
			next_st.bits[P_FSL] = 1'b1;
		end
		if (break_taken_event) begin
			next_st.bits[P_BIP] = 1'b1;
		end
		if (HAS_EXC && exception_return_event) begin
			next_st.bits[P_EIP] = 1'b0;
		end
		if (HAS_EXC && exception_entry_event) begin
			next_st.bits[P_EIP] = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================
	// Read view and control outputs
	always_comb begin
		machine_status        = st.bits & WR_MASK;
		machine_status[P_C]   = st.carry;
		machine_status[P_CC]  = st.carry;
		machine_status[P_PVR] = version_reg_param;
	end

	pcmsr_read_mux #(
		.DATA_W (DATA_W)
	) u_mux (
		.sel      (special_reg_selector_a),
		.pc_view  (pc_view),
		.msr_view (machine_status),
		.rd_data  (special_rd_data)
	);

	assign carry_flag            = carry_now;
	assign translation_enable    = (mmu_config_param == PCMSR_MMU_VIRTUAL) && st.bits[P_VM];
	assign protection_enable     = (mmu_config_param >= PCMSR_MMU_PROTECT) && st.bits[P_VM];
	assign user_mode_bit         = (mmu_config_param > 0) && st.bits[P_UM];
	assign exception_in_progress = HAS_EXC && st.bits[P_EIP];
	assign exception_take        = mmu_exception_req || (HAS_EXC && hw_exception_req && st.bits[P_EE]);
	assign dcache_enable         = dcache_present_param && st.bits[P_DCE];
	assign icache_enable         = icache_present_param && st.bits[P_ICE];
	assign break_in_progress     = st.bits[P_BIP];
	assign irq_enable            = st.bits[P_IE];
endmodule

// [design/pcmsr_pc.sv]
// Program counter register with base-vector reset and read-only selector view
`timescale 1ns/1ns
module pcmsr_pc
	import pcmsr_pkg::*;
#(
	parameter int                  ADDR_W            = 32,
	parameter logic [ADDR_W-1:0]   vector_base_param = '0
) (
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              pc_load,
	input  wire logic [ADDR_W-1:0] pc_next,
	output logic      [ADDR_W-1:0] program_counter
);
	typedef struct packed {
		logic [ADDR_W-1:0] pc;
	} pcmsr_pc_state_t;

	pcmsr_pc_state_t st;
	pcmsr_pc_state_t next_st;

	// ==========================================
	// Next state: only the pipeline moves the counter, never a register write
	always_comb begin
		next_st = st;
		if (pc_load) begin
			next_st.pc = pc_next;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st.pc <= vector_base_param;
		end else begin
			st <= next_st;
		end
	end

	assign program_counter = st.pc;
endmodule

// [design/pcmsr_pkg.sv]
// Package with selectors, bit positions and configuration codes of the program counter and status bank
package pcmsr_pkg;
	// ==========================================
	// Special register selectors
	localparam logic [15:0] PCMSR_SEL_PC  = 16'h0000;
	localparam logic [15:0] PCMSR_SEL_MSR = 16'h0001;
	localparam int          PCMSR_SEL_W   = 16;

	// ==========================================
	// Status bit positions, big-endian numbering, 32-bit layout
	localparam int PCMSR_B_CC  = 0;
	localparam int PCMSR_B_VMS = 17;
	localparam int PCMSR_B_VM  = 18;
	localparam int PCMSR_B_UMS = 19;
	localparam int PCMSR_B_UM  = 20;
	localparam int PCMSR_B_PVR = 21;
	localparam int PCMSR_B_EIP = 22;
	localparam int PCMSR_B_EE  = 23;
	localparam int PCMSR_B_DCE = 24;
	localparam int PCMSR_B_DZO = 25;
	localparam int PCMSR_B_ICE = 26;
	localparam int PCMSR_B_FSL = 27;
	localparam int PCMSR_B_BIP = 28;
	localparam int PCMSR_B_C   = 29;
	localparam int PCMSR_B_IE  = 30;
	localparam int PCMSR_SHIFT64 = 32;

	// ==========================================
	// Configuration codes
	localparam int PCMSR_MMU_PROTECT = 2;
	localparam int PCMSR_MMU_VIRTUAL = 3;
	localparam int PCMSR_AREA_SPEED  = 0;
	localparam int PCMSR_AREA_FREQ   = 2;
	localparam int PCMSR_W32         = 32;
	localparam int PCMSR_W64         = 64;

	// Maps a big-endian bit number to a little-endian index within a word of width w
	function automatic int pcmsr_pos(input int be_bit, input int w);
		return w - 1 - be_bit - ((w == PCMSR_W64) ? PCMSR_SHIFT64 : 0);
	endfunction
endpackage

// [design/pcmsr_read_mux.sv]
// Read multiplexer for the special register selector
`timescale 1ns/1ns
module pcmsr_read_mux
	import pcmsr_pkg::*;
#(
	parameter int DATA_W = 32
) (
	input  wire logic [PCMSR_SEL_W-1:0] sel,
	input  wire logic [DATA_W-1:0]      pc_view,
	input  wire logic [DATA_W-1:0]      msr_view,
	output logic      [DATA_W-1:0]      rd_data
);
	// ==========================================
	// Selection; unknown selectors read zero
	always_comb begin
		case (sel)
			PCMSR_SEL_PC:  rd_data = pc_view;
			PCMSR_SEL_MSR: rd_data = msr_view;
			default:       rd_data = '0;
		endcase
	end
endmodule

// [verification/pcmsr_bank_props.sv]
// Port checker for the program counter and status bank
`timescale 1ns/1ns
module pcmsr_bank_props
	import pcmsr_pkg::*;
#(
	parameter int                DATA_W            = 32,
	parameter int                ADDR_W            = 32,
	parameter logic [ADDR_W-1:0] vector_base_param = '0,
	parameter bit                version_reg_param = 1'b0
) (
	input wire logic              clk,
	input wire logic              sys_rst,
	input wire logic              pc_load,
	input wire logic [ADDR_W-1:0] pc_next,
	input wire logic [15:0]       special_reg_selector_a,
	input wire logic [DATA_W-1:0] special_rd_data,
	input wire logic              move_to_special,
	input wire logic [15:0]       special_reg_selector_x,
	input wire logic [DATA_W-1:0] move_to_special_data,
	input wire logic              status_bit_set_instr,
	input wire logic              status_bit_clear_instr,
	input wire logic [DATA_W-1:0] status_bit_mask,
	input wire logic              stream_mismatch_event,
	input wire logic              mmu_exception_req,
	input wire logic              carry_flag,
	input wire logic [DATA_W-1:0] machine_status,
	input wire logic              exception_take,
	input wire logic              dcache_enable,
	input wire logic              irq_enable
);
	// ====================
	// Flags sit in the low half of a 64-bit word
	localparam int TOP = DATA_W - 1 - ((DATA_W == PCMSR_W64) ? PCMSR_SHIFT64 : 0);
	localparam int CI  = TOP - PCMSR_B_C;
	localparam int II  = TOP - PCMSR_B_IE;
	localparam int DI  = TOP - PCMSR_B_DCE;
	localparam int FI  = TOP - PCMSR_B_FSL;
	localparam int PI  = TOP - PCMSR_B_PVR;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_quiet;
		!move_to_special && !status_bit_set_instr && !status_bit_clear_instr;
	endsequence
	sequence s_clr_dce;
		status_bit_clear_instr && !status_bit_set_instr && !move_to_special && status_bit_mask[DI];
	endsequence
	AST_PC_BASE: assert property ($fell(sys_rst) && special_reg_selector_a == PCMSR_SEL_PC
		|-> special_rd_data == DATA_W'(vector_base_param)) else $error("pc reset value wrong");
	AST_PC_FOLLOW: assert property (pc_load ##1 special_reg_selector_a == PCMSR_SEL_PC
		|-> special_rd_data == DATA_W'($past(pc_next))) else $error("pc read wrong");
	AST_PC_NO_MOVE: assert property (!pc_load && move_to_special && special_reg_selector_x == PCMSR_SEL_PC
		&& special_reg_selector_a == PCMSR_SEL_PC ##1 special_reg_selector_a == PCMSR_SEL_PC
		|-> $stable(special_rd_data)) else $error("move altered pc");
	AST_CC_MIRROR: assert property (machine_status[TOP] == machine_status[CI])
		else $error("carry copy differs");
	AST_PVR_FIXED: assert property (machine_status[PI] == version_reg_param)
		else $error("version bit moved");
	AST_SET_CARRY: assert property (status_bit_set_instr && !move_to_special && status_bit_mask[CI] |-> carry_flag)
		else $error("carry not set at once");
	AST_SET_IE: assert property (status_bit_set_instr && !move_to_special && status_bit_mask[II]
		|-> ##2 irq_enable) else $error("irq enable late");
	AST_CLR_DCE: assert property (s_quiet ##1 s_clr_dce |-> ##1 $stable(dcache_enable) ##1 !dcache_enable)
		else $error("cache enable clear timing");
	AST_MOVE_DCE: assert property (move_to_special && special_reg_selector_x == PCMSR_SEL_MSR
		|-> ##2 dcache_enable == $past(move_to_special_data[DI], 2)) else $error("move not applied");
	AST_STREAM_SET: assert property (stream_mismatch_event |=> machine_status[FI])
		else $error("stream error not flagged");
	AST_MMU_TAKE: assert property (mmu_exception_req |-> exception_take)
		else $error("mmu exception not taken");
endmodule

bind pcmsr_bank pcmsr_bank_props #(
	.DATA_W(DATA_W),
	.ADDR_W(ADDR_W),
	.vector_base_param(vector_base_param),
	.version_reg_param(version_reg_param)
) pcmsr_bank_props_inst (.*);

// [verification/pcmsr_bank_tb_top.sv]
// Self-checking bench for the program counter and status bank
`timescale 1ns/1ns
module pcmsr_bank_tb_top;
	import pcmsr_pkg::*;
	// ====================
	// Stimulus and bookkeeping
	localparam logic [31:0] VBASE = 32'h0000_0100;
	localparam logic [31:0] WMASK = 32'h0000_7BFE;
	localparam logic [31:0] PVRB  = 32'h0000_0400;
	logic        clk = 1'b0, sys_rst = 1'b1, run = 1'b0, stall = 1'b0, pc_load;
	logic        move_to_special = 1'b0, status_bit_set_instr = 1'b0, status_bit_clear_instr = 1'b0;
	logic        carry_update = 1'b0, carry_value = 1'b0, divide_fault_event = 1'b0, stream_mismatch_event = 1'b0;
	logic        break_taken_event = 1'b0, exception_entry_event = 1'b0, exception_return_event = 1'b0;
	logic        hw_exception_req = 1'b0, mmu_exception_req = 1'b0, carry_flag, translation_enable;
	logic        protection_enable, user_mode_bit, exception_in_progress, exception_take, dcache_enable;
	logic        icache_enable, break_in_progress, irq_enable;
	logic [15:0] special_reg_selector_a = PCMSR_SEL_PC, special_reg_selector_x = PCMSR_SEL_MSR;
	logic [31:0] move_to_special_data = '0, status_bit_mask = '0, pc_next, cur_pc, special_rd_data;
	logic [31:0] machine_status, exp_msr, v;
	integer      num_errors = 0, checks = 0, cycles = 0, seed = 32'h458e, k;
	wire  [6:0]  outs = {exception_take, irq_enable, dcache_enable, icache_enable, user_mode_bit,
		translation_enable, protection_enable};
	pcmsr_bank #(
		.vector_base_param(VBASE),
		.mmu_config_param(PCMSR_MMU_VIRTUAL),
		.version_reg_param(1'b1),
		.exception_param(1'b1),
		.dcache_present_param(1'b1),
		.icache_present_param(1'b1),
		.divider_present_param(1'b1),
		.stream_link_count_param(1)
	) pcmsr_bank_inst (.*);
	pcmsr_pipe_model #(.BASE(VBASE)) pcmsr_pipe_model_inst (.*);
	function automatic logic [31:0] apply(input logic [31:0] cur, input integer op, input logic [31:0] val);
		logic [31:0] r;
		r = (op == 0) ? val : (op == 1) ? (cur | val) : (cur & ~val);
		return (r & WMASK) | PVRB | {r[2], 31'h0};
	endfunction
	function automatic logic [6:0] exp_outs(input logic [31:0] m);
		return {mmu_exception_req | (hw_exception_req & m[8]), m[1], m[7], m[5], m[11], m[13], m[13]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic op(input integer kind, input logic [15:0] sel, input logic [31:0] val);
		@(negedge clk);
		move_to_special = (kind == 0);
		status_bit_set_instr = (kind == 1);
		status_bit_clear_instr = (kind == 2);
		special_reg_selector_x = sel;
		move_to_special_data = val;
		status_bit_mask = val;
	endtask
	task automatic idle();
		@(negedge clk);
		{move_to_special, status_bit_set_instr, status_bit_clear_instr, carry_update} = '0;
		{divide_fault_event, stream_mismatch_event, break_taken_event, exception_entry_event} = '0;
		exception_return_event = 1'b0;
		move_to_special_data = ~move_to_special_data;
		status_bit_mask = ~status_bit_mask;
	endtask
	task automatic summarize();
		if (num_errors == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			summarize();
		end
	end
	initial begin
		repeat (16) @(negedge clk);
		sys_rst = 1'b0;
		@(negedge clk);
		chk(special_rd_data, VBASE);
		chk(machine_status, PVRB);
		exp_msr = PVRB;
		op(0, PCMSR_SEL_PC, 32'hFFFF_FFFF);
		idle();
		@(negedge clk);
		chk(special_rd_data, VBASE);
		run <= 1'b1;
		repeat (30) begin
			@(negedge clk);
			stall <= 1'($random(seed));
		end
		run <= 1'b0;
		repeat (3) @(negedge clk);
		chk(special_rd_data, cur_pc);
		special_reg_selector_a = PCMSR_SEL_MSR;
		op(1, PCMSR_SEL_MSR, 32'h0000_0006);
		#1 chk({31'h0, carry_flag}, 32'h1);
		idle();
		chk({31'h0, irq_enable}, 32'h0);
		@(negedge clk);
		chk({31'h0, irq_enable}, 32'h1);
		{divide_fault_event, stream_mismatch_event, break_taken_event, exception_entry_event} = 4'hF;
		idle();
		chk(machine_status & 32'h0000_0258, 32'h0000_0258);
		chk({30'h0, exception_in_progress, break_in_progress}, 32'h3);
		op(2, PCMSR_SEL_MSR, 32'h0000_0010);
		exception_return_event = 1'b1;
		idle();
		@(negedge clk);
		chk(machine_status & 32'h0000_0210, 32'h0);
		chk({30'h0, exception_in_progress, break_in_progress}, 32'h1);
		for (int i = 0; i < 40; i++) begin
			{hw_exception_req, mmu_exception_req} = 2'($random(seed));
			// Break event stays up through the first staged write, so it overrides that write
			break_taken_event = 1'($random(seed));
			for (int j = 0; j < 2; j++) begin
				k = (i == 0) ? 0 : $unsigned($random(seed)) % 3;
				v = $random(seed);
				op(k, PCMSR_SEL_MSR, v);
				exp_msr = apply(exp_msr, k, v);
				if (j == 0) begin
					exp_msr[3] = exp_msr[3] | break_taken_event;
				end
			end
			idle();
			@(negedge clk);
			chk(machine_status, exp_msr);
			chk(special_rd_data, exp_msr);
			chk(32'(outs), 32'(exp_outs(exp_msr)));
		end
		carry_update = 1'b1;
		carry_value = ~exp_msr[2];
		exp_msr[2] = carry_value;
		exp_msr[31] = carry_value;
		idle();
		chk(machine_status, exp_msr);
		special_reg_selector_a = 16'h0002;
		#1 chk(special_rd_data, 32'h0);
		summarize();
	end
endmodule

// [verification/pcmsr_pipe_model.sv]
// Pipeline model that steps the program counter, with stalls
`timescale 1ns/1ns
module pcmsr_pipe_model #(
	parameter logic [31:0] BASE = 32'h0000_0100
) (
	input  wire logic   clk,
	input  wire logic   sys_rst,
	input  wire logic   run,
	input  wire logic   stall,
	output logic        pc_load = 1'b0,
	output logic [31:0] pc_next = 32'h0,
	output logic [31:0] cur_pc = 32'h0
);
	// An idle pipeline shows a scrambled address, never a stale one
	always @(negedge clk) begin
		pc_load <= run && !stall && !sys_rst;
		pc_next <= (run && !stall && !sys_rst) ? cur_pc + 32'h4 : ~cur_pc;
	end
	always @(posedge clk) begin
		if (sys_rst) begin
			cur_pc <= BASE;
		end else if (pc_load) begin
			cur_pc <= pc_next;
		end
	end
endmodule
